//--- core/ppn_core.v
// partition controls: stride and max bandwidth regulation, priorities, id narrowing
// assumes one clock, synchronous active-low reset, an AXI4-Lite master
//
// Local design decisions: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "ppn_defs.vh"

module ppn_core (
  input wire aclk, // clock
  input wire aresetn, // sync reset, low
  input wire [7:0] s_axi_awaddr, // write address
  input wire s_axi_awvalid, // write address valid
  output reg s_axi_awready, // write address ready
  input wire [31:0] s_axi_wdata, // write data
  input wire [3:0] s_axi_wstrb, // byte enables
  input wire s_axi_wvalid, // write data valid
  output reg s_axi_wready, // write data ready
  output reg [1:0] s_axi_bresp, // write response
  output reg s_axi_bvalid, // write response valid
  input wire s_axi_bready, // write response ready
  input wire [7:0] s_axi_araddr, // read address
  input wire s_axi_arvalid, // read address valid
  output reg s_axi_arready, // read address ready
  output reg [31:0] s_axi_rdata, // read data
  output reg [1:0] s_axi_rresp, // read response
  output reg s_axi_rvalid, // read valid
  input wire s_axi_rready, // read ready
  input wire up_valid, // upstream request valid
  output reg up_ready_q, // upstream request taken
  input wire [3:0] up_partition_id, // request partition id
  input wire up_ns, // nonsecure space flag
  input wire [3:0] up_priority, // upstream priority
  output reg down_valid_q, // downstream request valid
  input wire down_ready, // downstream accepts
  output reg [3:0] down_partition_id_q, // original request id
  output reg down_ns_q, // space flag
  output reg [3:0] down_priority_q, // transport priority
  output reg [3:0] down_int_priority_q, // internal tie-break priority
  input wire rsp_in_valid, // response from downstream
  output reg rsp_in_ready_q, // response taken
  input wire [3:0] rsp_in_priority, // response priority
  input wire [31:0] rsp_in_data, // response payload
  output reg rsp_out_valid_q, // response to upstream
  input wire rsp_out_ready, // upstream accepts
  output reg [3:0] rsp_out_priority_q, // forwarded priority
  output reg [31:0] rsp_out_data_q // forwarded payload
);

  function is_cfg;
    input [7:0] a;
    begin
      is_cfg = (a == `PPN_A_CPBM) || (a == `PPN_A_CMAX) || (a == `PPN_A_BPBM) ||
               (a == `PPN_A_BMAX) || (a == `PPN_A_PROP) || (a == `PPN_A_PRIO);
    end
  endfunction

  function is_known;
    input [7:0] a;
    begin
      is_known = is_cfg(a) || (a == `PPN_A_FEAT) || (a == `PPN_A_BWID) || (a == `PPN_A_ESR) ||
                 (a == `PPN_A_SEL) || (a == `PPN_A_MAP) || (a == `PPN_A_VPID);
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
      end
    end
  endfunction

  // per-space, per-partition settings: index {ns, id}
  reg [7:0] cpbm_q [0:31];
  reg [11:0] cmax_q [0:31];
  reg [7:0] bpbm_q [0:31];
  reg [11:0] bmax_q [0:31];
  reg [15:0] stride_q [0:31];
  reg en_q [0:31];
  reg [3:0] iprio_q [0:31];
  reg [3:0] dprio_q [0:31];
  reg [3:0] map_q [0:31];
  reg [7:0] usage_q [0:31];
  reg [15:0] pass_q [0:31];

  reg [3:0] sel_id_q;
  reg sel_int_q;
  reg sel_ns_q;
  reg [3:0] err_q;
  reg [7:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg aw_held_q;
  reg w_held_q;
  reg hold_q;
  reg [3:0] h_pid_q;
  reg h_ns_q;
  reg [3:0] h_prio_q;
  reg [4:0] h_idx_q;
  reg [15:0] vt_q;
  reg [7:0] win_q;

  wire [4:0] cfg_idx = {sel_ns_q, sel_id_q};
  // selector checks for config and map access
  wire cfg_ok = `PPN_HAS_NARROW ? (sel_int_q && sel_id_q < `PPN_NUM_INT) : !sel_int_q; // RULE15 RULE16
  wire map_ok = `PPN_HAS_NARROW && !sel_int_q; // RULE15
  wire wr_do = aw_held_q && w_held_q && !s_axi_bvalid;
  wire rd_do = s_axi_arvalid && s_axi_arready;
  wire [31:0] wr_val;
  reg [31:0] rd_val;
  reg [31:0] cur_val;

  // current contents of a register, used for reads and byte-lane merges
  always @* begin
    cur_val = 32'h0000_0000;
    if (s_axi_arvalid && s_axi_arready) begin
      cur_val = 32'h0000_0000;
    end
    rd_val = 32'h0000_0000;
    if (s_axi_araddr == `PPN_A_FEAT) begin
      rd_val = {28'h000_0000, `PPN_HAS_DS_PRIO, `PPN_HAS_INT_PRIO, `PPN_HAS_NARROW, `PPN_HAS_VENDOR}; // RULE10 RULE7
    end else if (s_axi_araddr == `PPN_A_BWID) begin
      rd_val = {31'h0000_0000, `PPN_HAS_STRIDE}; // RULE2
    end else if (s_axi_araddr == `PPN_A_ESR) begin
      rd_val = {28'h000_0000, err_q};
    end else if (s_axi_araddr == `PPN_A_SEL) begin
      rd_val = {14'h0000, sel_ns_q, sel_int_q, 12'h000, sel_id_q};
    end else if (s_axi_araddr == `PPN_A_MAP) begin
      rd_val = map_ok ? {28'h000_0000, map_q[cfg_idx]} : 32'h0000_0000; // RULE13
    end else if (s_axi_araddr == `PPN_A_VPID) begin
      rd_val = `PPN_VENDOR_ID; // arbitrary value
    end else if (cfg_ok) begin
      if (s_axi_araddr == `PPN_A_CPBM) begin
        rd_val = {24'h00_0000, cpbm_q[cfg_idx]};
      end else if (s_axi_araddr == `PPN_A_CMAX) begin
        rd_val = {16'h0000, cmax_q[cfg_idx], 4'h0}; // RULE20
      end else if (s_axi_araddr == `PPN_A_BPBM) begin
        rd_val = {24'h00_0000, bpbm_q[cfg_idx]};
      end else if (s_axi_araddr == `PPN_A_BMAX) begin
        rd_val = {16'h0000, bmax_q[cfg_idx], 4'h0}; // RULE20
      end else if (s_axi_araddr == `PPN_A_PROP) begin
        rd_val = {en_q[cfg_idx], 15'h0000, stride_q[cfg_idx]};
      end else if (s_axi_araddr == `PPN_A_PRIO) begin
        rd_val = {12'h000, dprio_q[cfg_idx], 12'h000, iprio_q[cfg_idx]};
      end
    end
    if (aw_addr_q == `PPN_A_SEL) begin
      cur_val = {14'h0000, sel_ns_q, sel_int_q, 12'h000, sel_id_q};
    end else if (aw_addr_q == `PPN_A_MAP) begin
      cur_val = {28'h000_0000, map_q[cfg_idx]};
    end else if (aw_addr_q == `PPN_A_CPBM) begin
      cur_val = {24'h00_0000, cpbm_q[cfg_idx]};
    end else if (aw_addr_q == `PPN_A_CMAX) begin
      cur_val = {16'h0000, cmax_q[cfg_idx], 4'h0};
    end else if (aw_addr_q == `PPN_A_BPBM) begin
      cur_val = {24'h00_0000, bpbm_q[cfg_idx]};
    end else if (aw_addr_q == `PPN_A_BMAX) begin
      cur_val = {16'h0000, bmax_q[cfg_idx], 4'h0};
    end else if (aw_addr_q == `PPN_A_PROP) begin
      cur_val = {en_q[cfg_idx], 15'h0000, stride_q[cfg_idx]};
    end else if (aw_addr_q == `PPN_A_PRIO) begin
      cur_val = {12'h000, dprio_q[cfg_idx], 12'h000, iprio_q[cfg_idx]};
    end
  end

  assign wr_val = merge(cur_val, w_data_q, w_strb_q);

  wire sel_err = (wr_do && is_cfg(aw_addr_q) && !cfg_ok) || (wr_do && aw_addr_q == `PPN_A_MAP && !map_ok) ||
                 (rd_do && is_cfg(s_axi_araddr) && !cfg_ok) || (rd_do && s_axi_araddr == `PPN_A_MAP && !map_ok);

  // write channel: address and data taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PPN_RESP_OKAY;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_q <= s_axi_awaddr;
        aw_held_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        w_held_q <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_do) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_known(aw_addr_q) ? `PPN_RESP_OKAY : `PPN_RESP_DECERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // read channel: answer one cycle after the address is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PPN_RESP_OKAY;
    end else if (rd_do) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= is_known(s_axi_araddr) ? `PPN_RESP_OKAY : `PPN_RESP_DECERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // selector and settings; every map entry resets, other settings only for the default partition of each space
  integer k;
  always @(posedge aclk) begin
    if (!aresetn) begin
      sel_id_q <= 4'h0;
      sel_int_q <= 1'b0;
      sel_ns_q <= 1'b0;
      for (k = 0; k < 32; k = k + 1) begin
        map_q[k] <= 4'h0; // RULE19
      end
      for (k = 0; k < 32; k = k + 16) begin
        cpbm_q[k] <= `PPN_RST_BITMAP; // RULE17 RULE18
        bpbm_q[k] <= `PPN_RST_BITMAP; // RULE18
        cmax_q[k] <= `PPN_RST_FRAC; // RULE18
        bmax_q[k] <= `PPN_RST_FRAC; // RULE18
        en_q[k] <= 1'b0; // RULE18
        stride_q[k] <= 16'h0000;
        iprio_q[k] <= 4'h0;
        dprio_q[k] <= 4'h0;
      end
    end else if (wr_do) begin
      if (aw_addr_q == `PPN_A_SEL) begin
        sel_id_q <= wr_val[3:0];
        sel_int_q <= wr_val[`PPN_SEL_INT_BIT];
        sel_ns_q <= wr_val[`PPN_SEL_NS_BIT];
      end else if (aw_addr_q == `PPN_A_MAP && map_ok) begin
        map_q[cfg_idx] <= wr_val[3:0]; // RULE13
      end else if (cfg_ok) begin
        if (aw_addr_q == `PPN_A_CPBM) begin
          cpbm_q[cfg_idx] <= wr_val[7:0];
        end else if (aw_addr_q == `PPN_A_CMAX) begin
          cmax_q[cfg_idx] <= wr_val[15:4]; // RULE20
        end else if (aw_addr_q == `PPN_A_BPBM) begin
          bpbm_q[cfg_idx] <= wr_val[7:0];
        end else if (aw_addr_q == `PPN_A_BMAX) begin
          bmax_q[cfg_idx] <= wr_val[15:4]; // RULE20
        end else if (aw_addr_q == `PPN_A_PROP) begin
          stride_q[cfg_idx] <= wr_val[15:0]; // RULE1
          en_q[cfg_idx] <= wr_val[`PPN_PROP_EN_BIT]; // RULE3
        end else if (aw_addr_q == `PPN_A_PRIO) begin
          iprio_q[cfg_idx] <= wr_val[3:0];
          dprio_q[cfg_idx] <= wr_val[`PPN_DSPRIO_LSB +: 4];
        end
      end
    end
  end

  // narrowing of an arriving request
  wire [4:0] raw_idx = {up_ns, up_partition_id};
  wire [3:0] mapped = map_q[raw_idx];
  wire map_bad = `PPN_HAS_NARROW && (mapped >= `PPN_NUM_INT);
  wire [4:0] arr_idx = !`PPN_HAS_NARROW ? raw_idx : (map_bad ? {up_ns, 4'h0} : {up_ns, mapped}); // RULE11
  wire take = up_valid && up_ready_q;

  // error status: a new event wins over a clearing write
  always @(posedge aclk) begin
    if (!aresetn) begin
      err_q <= `PPN_ERR_NONE;
    end else if (take && map_bad) begin
      err_q <= `PPN_ERR_MAP; // RULE14
    end else if (sel_err) begin
      err_q <= `PPN_ERR_SEL;
    end else if (wr_do && aw_addr_q == `PPN_A_ESR) begin
      err_q <= `PPN_ERR_NONE;
    end
  end

  // regulation of the held request
  wire [15:0] lead = pass_q[h_idx_q] - vt_q;
  wire stride_hold = en_q[h_idx_q] && !lead[15] && (lead != 16'h0000); // RULE3 RULE21
  wire [7:0] lim = bmax_q[h_idx_q][11:4];
  wire max_hold = (lim != 8'hFF) && (usage_q[h_idx_q] >= lim);
  wire blocked = max_hold || stride_hold; // RULE4
  wire issue = hold_q && !blocked && (!down_valid_q || down_ready);
  wire [15:0] base = lead[15] ? vt_q : pass_q[h_idx_q];
  wire win_end = ({24'h00_0000, win_q} == (`PPN_WIN_CYC - 1));
  integer j;

  always @(posedge aclk) begin
    if (!aresetn) begin
      up_ready_q <= 1'b1;
      hold_q <= 1'b0;
      h_pid_q <= 4'h0;
      h_ns_q <= 1'b0;
      h_prio_q <= 4'h0;
      h_idx_q <= 5'h00;
      vt_q <= 16'h0000;
      win_q <= 8'h00;
      down_valid_q <= 1'b0;
      down_partition_id_q <= 4'h0;
      down_ns_q <= 1'b0;
      down_priority_q <= 4'h0;
      down_int_priority_q <= 4'h0;
      for (j = 0; j < 32; j = j + 1) begin
        usage_q[j] <= 8'h00;
        pass_q[j] <= 16'h0000;
      end
    end else begin
      win_q <= win_end ? 8'h00 : win_q + 8'h01;
      if (hold_q) begin
        vt_q <= vt_q + 16'h0001; // RULE1
      end
      if (down_valid_q && down_ready) begin
        down_valid_q <= 1'b0;
      end
      if (take) begin
        hold_q <= 1'b1;
        up_ready_q <= 1'b0;
        h_pid_q <= up_partition_id;
        h_ns_q <= up_ns;
        h_prio_q <= up_priority;
        h_idx_q <= arr_idx; // RULE11
      end
      for (j = 0; j < 32; j = j + 1) begin
        if (win_end) begin
          usage_q[j] <= 8'h00;
        end
      end
      if (issue) begin
        hold_q <= 1'b0;
        up_ready_q <= 1'b1;
        down_valid_q <= 1'b1;
        down_partition_id_q <= h_pid_q; // RULE12
        down_ns_q <= h_ns_q;
        down_priority_q <= `PPN_HAS_DS_PRIO ? dprio_q[h_idx_q] : h_prio_q; // RULE6 RULE8 RULE7
        down_int_priority_q <= `PPN_HAS_INT_PRIO ? iprio_q[h_idx_q] : h_prio_q; // RULE5 RULE7
        if (!win_end) begin
          usage_q[h_idx_q] <= usage_q[h_idx_q] + 8'h01;
        end
        if (en_q[h_idx_q]) begin
          pass_q[h_idx_q] <= base + stride_q[h_idx_q] + 16'h0001; // RULE1
        end
      end
    end
  end

  // responses pass with their own priority
  always @(posedge aclk) begin
    if (!aresetn) begin
      rsp_in_ready_q <= 1'b1;
      rsp_out_valid_q <= 1'b0;
      rsp_out_priority_q <= 4'h0;
      rsp_out_data_q <= 32'h0000_0000;
    end else if (rsp_in_valid && rsp_in_ready_q) begin
      rsp_in_ready_q <= 1'b0;
      rsp_out_valid_q <= 1'b1;
      rsp_out_priority_q <= rsp_in_priority; // RULE9
      rsp_out_data_q <= rsp_in_data;
    end else if (rsp_out_valid_q && rsp_out_ready) begin
      rsp_out_valid_q <= 1'b0;
      rsp_in_ready_q <= 1'b1;
    end
  end

endmodule // ppn_core

//--- core/ppn_defs.vh
// constants for the partition priority and narrowing block
// assumes inclusion by the core and the bench; byte addresses on an 8-bit bus offset
//
// Operation
// RULE1: stride value is unsigned; bandwidth share follows stride among contenders
// RULE2: read-only feature bit reports stride control present
// RULE3: stride regulation only when the partition enable is 1
// RULE4: maximum limit and stride regulation both constrain when both active
// RULE5: internal priority breaks ties between equal-preference waiting requests
// RULE6: downstream priority comes from the partition's configured value
// RULE7: internal and downstream priority controls are separate options
// RULE8: without downstream control, downstream priority equals upstream priority
// RULE9: responses keep their received priority unchanged
// RULE10: feature bit reports vendor parameter register and vendor controls
// RULE11: request id and space flag narrowed before controls are consulted
// RULE12: downstream requests carry the original request partition id
// RULE13: mapping register reaches entry of selector's request partition id
// RULE14: bad narrowing map reported as error code in error status
// RULE15: software clears internal flag for map access, sets it otherwise
// RULE16: without narrowing selector is a request id, internal flag zero
// RULE17: default partition controls reset in each space to full access
// RULE18: partition 0 resets to all-ones bitmaps, 0xFFFF maxima, stride off; maxima here reset to 12'hFFF and read 0xFFF0
// RULE19: request id 0 maps to internal id 0 after reset
// RULE20: fractions are 16-bit; dropped low bits read zero, ignore writes
// RULE21: stride enable clear means no stride-based holding
`ifndef PPN_DEFS_VH
`define PPN_DEFS_VH

`define PPN_A_FEAT 8'h00
`define PPN_A_BWID 8'h04
`define PPN_A_ESR 8'h08
`define PPN_A_SEL 8'h0C
`define PPN_A_MAP 8'h10
`define PPN_A_CPBM 8'h14
`define PPN_A_CMAX 8'h18
`define PPN_A_BPBM 8'h1C
`define PPN_A_BMAX 8'h20
`define PPN_A_PROP 8'h24
`define PPN_A_PRIO 8'h28
`define PPN_A_VPID 8'h2C

`define PPN_HAS_NARROW 1'b1
`define PPN_HAS_INT_PRIO 1'b1
`define PPN_HAS_DS_PRIO 1'b1
`define PPN_HAS_STRIDE 1'b1
`define PPN_HAS_VENDOR 1'b1
`define PPN_NUM_INT 4'h4
`define PPN_VENDOR_ID 32'h0000_5A5A

`define PPN_SEL_INT_BIT 16
`define PPN_SEL_NS_BIT 17
`define PPN_PROP_EN_BIT 31
`define PPN_DSPRIO_LSB 16

`define PPN_ERR_NONE 4'h0
`define PPN_ERR_SEL 4'h1
`define PPN_ERR_MAP 4'h2

`define PPN_RST_BITMAP 8'hFF
`define PPN_RST_FRAC 12'hFFF

`define PPN_CLK_NS 20
`define PPN_WIN_NS 5120
`define PPN_WIN_CYC (`PPN_WIN_NS / `PPN_CLK_NS)

`define PPN_RESP_OKAY 2'b00
`define PPN_RESP_DECERR 2'b11

`endif

//--- testbench/ppn_core_sva.sv
// checker: handshake and pass-through relations at the ppn_core ports
// assumes a bind from the bench top; one clock, sync low reset
`timescale 1ns/1ps
module ppn_chk (
  input wire logic aclk, // clock
  input wire logic aresetn, // reset, low
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_rready, // r ready
  input wire logic [31:0] s_axi_rdata, // r data
  input wire logic up_valid, // request valid
  input wire logic up_ready_q, // request slot
  input wire logic down_valid_q, // issued
  input wire logic down_ready, // issue taken
  input wire logic [3:0] down_partition_id_q, // issued id
  input wire logic [3:0] down_priority_q, // issued prio
  input wire logic rsp_in_valid, // resp in
  input wire logic rsp_in_ready_q, // resp in taken
  input wire logic [3:0] rsp_in_priority, // resp in prio
  input wire logic rsp_out_valid_q, // resp out
  input wire logic rsp_out_ready, // resp out taken
  input wire logic [3:0] rsp_out_priority_q // resp out prio
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_reset_idle: assert property (disable iff (1'b0) !aresetn |=> s_axi_awready && s_axi_arready && up_ready_q
    && rsp_in_ready_q && !s_axi_bvalid && !s_axi_rvalid && !down_valid_q && !rsp_out_valid_q)
    else $error("outputs not idle after reset");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write response missing");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_up_refused: assert property (up_valid && up_ready_q |=> !up_ready_q)
    else $error("second request slot open");
  a_down_stands: assert property (down_valid_q && !down_ready |=> down_valid_q
    && $stable(down_partition_id_q) && $stable(down_priority_q)) else $error("issued request changed");
  a_resp_prio_kept: assert property (rsp_in_valid && rsp_in_ready_q |=> rsp_out_valid_q
    && rsp_out_priority_q == $past(rsp_in_priority) && !rsp_in_ready_q) else $error("response priority altered");
  a_resp_stands: assert property (rsp_out_valid_q && !rsp_out_ready |=> rsp_out_valid_q
    && $stable(rsp_out_priority_q)) else $error("response dropped");
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_issue: cover property (down_valid_q && !down_ready ##1 down_valid_q && down_ready);
  c_resp: cover property (rsp_out_valid_q && rsp_out_ready);
endmodule // ppn_chk

//--- testbench/ppn_core_tb_top.sv
// bench: register setup over AXI4-Lite, request traffic, queued expectations
// assumes ppn_core, ppn_far_model and ppn_chk compiled beforehand
`timescale 1ns/1ps
`include "ppn_defs.vh"
module ppn_core_tb_top;
  logic aclk = 1'b0, aresetn = 1'b0, slow = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic up_valid = 1'b0, up_ns = 1'b0, rsp_out_ready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [3:0] s_axi_wstrb = 4'hF, up_partition_id = 4'h0, up_priority = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rsp_in_data, rsp_out_data_q;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, up_ready_q, down_valid_q;
  logic down_ready, down_ns_q, rsp_in_valid, rsp_in_ready_q, rsp_out_valid_q;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [3:0] down_partition_id_q, down_priority_q, down_int_priority_q, rsp_in_priority, rsp_out_priority_q;
  logic [3:0] mp [2][16];
  logic [3:0] dsp [2][4];
  logic [3:0] inp [2][4];
  logic [63:0] rq [$], dq [$], pq [$], bq [$];
  int num_errors = 0, checks_done = 0, seed = 98, cyc = 0, t;

  ppn_core u_dut (.*);
  ppn_far_model u_far (.*);
  always #10 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("comparisons %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = `PPN_RESP_OKAY);
    bq.push_back(64'(r));
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = `PPN_RESP_OKAY);
    rq.push_back({30'h0, r, d});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask

  task automatic sel(input logic ns, input logic in, input logic [3:0] id);
    wr(`PPN_A_SEL, {14'h0, ns, in, 12'h0, id});
  endtask

  // bad map entries fall back to partition 0 of the space
  task automatic up(input logic [3:0] id, input logic ns);
    logic [3:0] ip;
    ip = (mp[ns][id] > 4'h3) ? 4'h0 : mp[ns][id];
    dq.push_back({id, ns, dsp[ns][ip], inp[ns][ip]});
    pq.push_back({~dsp[ns][ip], 24'h00_0000, ns, 3'h0, id});
    @(posedge aclk);
    up_partition_id <= id;
    up_ns <= ns;
    up_priority <= 4'($random(seed));
    up_valid <= 1'b1;
    do @(posedge aclk); while (!up_ready_q);
    up_valid <= 1'b0;
  endtask

  task automatic burst(input int n, output int c);
    c = cyc;
    repeat (n) up(4'h0, 1'b0);
    c = cyc - c;
  endtask

  always @(posedge aclk) begin
    rsp_out_ready <= slow ? 1'($random(seed)) : 1'b1;
    if (aresetn) begin
      if (s_axi_bvalid && s_axi_bready) chk(64'(s_axi_bresp), bq.pop_front());
      if (s_axi_rvalid && s_axi_rready) chk(64'({s_axi_rresp, s_axi_rdata}), rq.pop_front());
      if (down_valid_q && down_ready)
        chk(64'({down_partition_id_q, down_ns_q, down_priority_q, down_int_priority_q}), dq.pop_front());
      if (rsp_out_valid_q && rsp_out_ready) chk(64'({rsp_out_priority_q, rsp_out_data_q}), pq.pop_front());
    end
  end

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`PPN_A_FEAT, 32'h0000_000F);
    rd(`PPN_A_BWID, 32'h0000_0001);
    rd(`PPN_A_VPID, `PPN_VENDOR_ID);
    for (int n = 0; n < 2; n++) begin
      sel(n[0], 1'b0, 4'h0);
      rd(`PPN_A_MAP, 32'h0000_0000);
      sel(n[0], 1'b1, 4'h0);
      rd(`PPN_A_CPBM, 32'h0000_00FF);
      rd(`PPN_A_CMAX, 32'h0000_FFF0);
      rd(`PPN_A_BPBM, 32'h0000_00FF);
      rd(`PPN_A_BMAX, 32'h0000_FFF0);
      rd(`PPN_A_PROP, 32'h0000_0000);
    end
    wr(`PPN_A_CMAX, 32'h0000_1234);
    rd(`PPN_A_CMAX, 32'h0000_1230);
    sel(1'b0, 1'b0, 4'h0);
    wr(`PPN_A_CPBM, 32'h0000_0000);
    rd(`PPN_A_ESR, 32'h0000_0001);
    wr(`PPN_A_ESR, 32'h0000_0000);
    rd(`PPN_A_ESR, 32'h0000_0000);
    sel(1'b0, 1'b1, 4'h0);
    rd(`PPN_A_CPBM, 32'h0000_00FF);
    rd(8'h30, 32'h0000_0000, `PPN_RESP_DECERR);
    wr(8'h30, 32'h0000_0001, `PPN_RESP_DECERR);
    for (int n = 0; n < 8; n++) begin
      dsp[n[2]][n[1:0]] = 4'($random(seed));
      inp[n[2]][n[1:0]] = 4'($random(seed));
      sel(n[2], 1'b1, 4'(n[1:0]));
      wr(`PPN_A_BMAX, 32'h0000_FFFF);
      wr(`PPN_A_PROP, 32'h0000_0000);
      wr(`PPN_A_PRIO, {12'h0, dsp[n[2]][n[1:0]], 12'h0, inp[n[2]][n[1:0]]});
    end
    for (int n = 0; n < 32; n++) begin
      mp[n[4]][n[3:0]] = (n == 31) ? 4'h4 : 4'({$random(seed)} % 4);
      sel(n[4], 1'b0, n[3:0]);
      wr(`PPN_A_MAP, {28'h0, mp[n[4]][n[3:0]]});
      rd(`PPN_A_MAP, {28'h0, mp[n[4]][n[3:0]]});
    end
    slow <= 1'b1;
    repeat (24) up(4'($random(seed)), 1'($random(seed)));
    up(4'hF, 1'b1);
    rd(`PPN_A_ESR, 32'h0000_0002);
    slow <= 1'b0;
    t = 0;
    while ((dq.size() + pq.size()) > 0 && t < 500) begin
      @(posedge aclk);
      t++;
    end
    sel(1'b0, 1'b0, 4'h0);
    wr(`PPN_A_MAP, 32'h0000_0001);
    mp[0][0] = 4'h1;
    sel(1'b0, 1'b1, 4'h1);
    wr(`PPN_A_PROP, 32'h0000_0063);
    burst(4, t);
    chk(64'(t < 40), 64'h1);
    wr(`PPN_A_PROP, 32'h8000_0063);
    burst(4, t);
    chk(64'(t >= 200), 64'h1);
    wr(`PPN_A_PROP, 32'h0000_0000);
    wr(`PPN_A_BMAX, 32'h0000_0300);
    burst(10, t);
    chk(64'(t > 256), 64'h1);
    t = 0;
    while ((dq.size() + pq.size()) > 0 && t < 600) begin
      @(posedge aclk);
      t++;
    end
    chk(64'(dq.size() + pq.size()), 64'h0);
    results();
  end

  initial begin
    repeat (60000) @(posedge aclk);
    num_errors++;
    results();
  end
endmodule // ppn_core_tb_top

bind ppn_core ppn_chk u_chk (.*);

//--- testbench/ppn_far_model.sv
// far side: downstream acceptor that answers each taken request
// assumes the ppn_core clock and reset; stalls at random when slow is high
`timescale 1ns/1ps
module ppn_far_model (
  input wire logic aclk, // clock
  input wire logic aresetn, // reset, low
  input wire logic slow, // random stalls
  input wire logic down_valid_q, // request offered
  input wire logic [3:0] down_partition_id_q, // request id
  input wire logic down_ns_q, // space flag
  input wire logic [3:0] down_priority_q, // transport prio
  input wire logic rsp_in_ready_q, // response taken
  output logic down_ready, // request accepted
  output logic rsp_in_valid, // response offered
  output logic [3:0] rsp_in_priority, // response prio
  output logic [31:0] rsp_in_data // response payload
);
  int s = 98;
  logic [35:0] q [$];
  always @(posedge aclk) begin
    if (!aresetn) begin
      down_ready <= 1'b0;
      rsp_in_valid <= 1'b0;
      {rsp_in_priority, rsp_in_data} <= 36'h0_0000_0000;
    end else begin
      down_ready <= slow ? 1'($random(s)) : 1'b1;
      if (down_valid_q && down_ready) q.push_back({~down_priority_q, 24'h00_0000, down_ns_q, 3'h0, down_partition_id_q});
      if (rsp_in_valid && rsp_in_ready_q) begin
        rsp_in_valid <= 1'b0;
        // released payload does not keep its last value
        {rsp_in_priority, rsp_in_data} <= ~{rsp_in_priority, rsp_in_data};
      end else if (!rsp_in_valid && q.size() > 0) begin
        {rsp_in_priority, rsp_in_data} <= q.pop_front();
        rsp_in_valid <= 1'b1;
      end
    end
  end
endmodule // ppn_far_model
